// *** rtl/csm_params.svh ***
`ifndef CSM_PARAMS_SVH
`define CSM_PARAMS_SVH

// Bit of the system configuration word that switches the monitor off.
`define CSM_CFG_MON_DIS_BIT   4
`define CSM_CFG_WIDTH         16
// Free-running PLL cycles with no oscillator edge before loss is declared.
`define CSM_MON_LIMIT         16
// Clock rate and the modelled free-running PLL rate.
`define CSM_CLK_HZ            50000000
`define CSM_PLL_FREE_HZ       12500000
`define CSM_PLL_FREE_DIV      (`CSM_CLK_HZ / `CSM_PLL_FREE_HZ)
// Strap codes for the two non-PLL modes.
`define CSM_STRAP_PRESCALE    3'h1
`define CSM_STRAP_DIRECT      3'h3
// Start value of the PLL half-period estimate, in clock cycles.
`define CSM_EST_RESET         16'h0010

`endif

// *** rtl/csm_pkg.sv ***
package csm_pkg;

    typedef enum logic [1:0] {
        CSM_MODE_DIRECT,
        CSM_MODE_PRESCALE,
        CSM_MODE_PLL
    } csm_mode_t;

    // Outputs that carry the CPU clock tick, its source, the PLL enable and the clock-fail irq.
    typedef struct packed {
        logic cpu_tick;
        logic src_pll;
        logic pll_enable;
        logic fail_irq;
    } csm_status_t;

    // Multiplication factor times two, so 1.5 and 2.5 stay whole.
    function automatic logic [3:0] factor2(input logic [2:0] straps);
        case (straps)
            3'h7: factor2 = 4'h8;
            3'h6: factor2 = 4'h6;
            3'h5: factor2 = 4'h4;
            3'h4: factor2 = 4'ha;
            3'h2: factor2 = 4'h3;
            3'h0: factor2 = 4'h5;
            default: factor2 = 4'h2;
        endcase
    endfunction

endpackage

// *** rtl/csm_loss_counter.sv ***
`timescale 1ns/1ps
`include "csm_params.svh"

module csm_loss_counter #(
    parameter int LIMIT = `CSM_MON_LIMIT
) (
    // Clock and reset.
    input  wire logic clock_in,
    input  wire logic srst_in,
    // Control.
    input  wire logic enable_in,
    input  wire logic clear_in,
    input  wire logic inc_in,
    // Result.
    output logic      overflow_out
);
    localparam int W = $clog2(LIMIT + 1);

    generate
        if (LIMIT < 2) begin : g_chk
            $error("csm_loss_counter: LIMIT must be at least 2");
        end
    endgenerate

    logic [W-1:0] count;
    logic [W-1:0] next_count;
    logic         next_overflow;

    always_comb begin
        next_count    = count;
        next_overflow = 1'b0;
        if (!enable_in) begin
            next_count = '0;
        end else if (clear_in) begin
            next_count = '0;
        end else if (inc_in) begin
            if (count == W'(LIMIT - 1)) begin
                next_count    = '0;
                next_overflow = 1'b1;
            end else begin
                next_count = count + 1'b1;
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            count        <= '0;
            overflow_out <= 1'b0;
        end else begin
            count        <= next_count;
            overflow_out <= next_overflow;
        end
    end

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (srst_in);

    property p_clear_zero;
        enable_in && clear_in |=> count == '0;
    endproperty
    a_clear_zero: assert property (p_clear_zero)
        else $error("count not cleared by oscillator edge");

    property p_ovf_cause;
        overflow_out |-> $past(count) == W'(LIMIT - 1) && $past(inc_in);
    endproperty
    a_ovf_cause: assert property (p_ovf_cause)
        else $error("overflow without reaching the limit");

endmodule // csm_loss_counter

// *** rtl/csm_top.sv ***
// What this block does
// - Monitor runs after every reset with no software action.
// - Configuration bit 4 set switches the monitor off.
// - Active monitor keeps PLL free-running; each PLL cycle counts.
// - Every oscillator input transition clears the monitor count.
// - Sixteen PLL cycles without a transition means the clock is lost.
// - On loss, CPU clock moves to free-running PLL and irq flag sets.
// - After loss, CPU stays on PLL until the next hardware reset.
// - Monitor off: CPU clock from oscillator, PLL powered down.
// - Monitor applies only in direct drive and prescaler modes.
// - Other strap codes enable PLL, CPU clock is input times factor.
// - PLL resyncs to input every F-th transition, adjusting gradually.
// - Straps 001 give oscillator divided by two.
// - Straps 011 give CPU clock straight from oscillator.
`timescale 1ns/1ps
`include "csm_params.svh"

module csm_top #(
    parameter int PLL_FREE_DIV = `CSM_PLL_FREE_DIV,
    parameter int MON_LIMIT    = `CSM_MON_LIMIT
) (
    // Clock and reset.
    input  wire logic                      clock_in,
    input  wire logic                      srst_in,
    // Pins from outside.
    input  wire logic                      oscillator_input_pin_in,
    input  wire logic [2:0]                clock_mode_straps_in,
    // System configuration word and irq acknowledge.
    input  wire logic [`CSM_CFG_WIDTH-1:0] system_config_register_in,
    input  wire logic                      oscillator_fail_irq_clear_in,
    // Clock status toward CPU clock tree and interrupt system.
    output logic                           cpu_tick_out,
    output logic                           cpu_src_pll_out,
    output logic                           pll_enable_out,
    output logic                           oscillator_fail_irq_out,
    output logic [1:0]                     clock_mode_out
);
    generate
        if (PLL_FREE_DIV < 2 || PLL_FREE_DIV > 256) begin : g_chk
            $error("csm_top: PLL_FREE_DIV must lie in 2 to 256");
        end
    endgenerate

    // Pin synchronisers; the first stage feeds only the second.
    logic       osc_s1;
    logic       osc_s2;
    logic       osc_s3;
    logic [2:0] strap_s1;
    logic [2:0] strap_s2;

    always_ff @(posedge clock_in) begin
        osc_s1   <= oscillator_input_pin_in;
        osc_s2   <= osc_s1;
        osc_s3   <= osc_s2;
        strap_s1 <= clock_mode_straps_in;
        strap_s2 <= strap_s1;
    end

    logic osc_edge;
    logic osc_rise;
    assign osc_edge = osc_s2 ^ osc_s3;
    assign osc_rise = osc_s2 & ~osc_s3;

    // Mode, failure and irq state.
    csm_pkg::csm_mode_t mode;
    csm_pkg::csm_mode_t next_mode;
    logic [3:0]         f2;
    logic [3:0]         next_f2;
    logic               failed;
    logic               next_failed;
    logic               next_irq;
    logic               mon_dis;
    logic               mon_on;
    logic               overflow;

    assign mon_dis = system_config_register_in[`CSM_CFG_MON_DIS_BIT];
    assign mon_on = (mode != csm_pkg::CSM_MODE_PLL) && !mon_dis && !failed;

    always_comb begin
        next_mode   = mode;
        next_f2     = f2;
        next_failed = failed;
        next_irq    = oscillator_fail_irq_out;
        if (srst_in) begin
            next_f2 = csm_pkg::factor2(strap_s2);
            if (strap_s2 == `CSM_STRAP_PRESCALE) begin
                next_mode = csm_pkg::CSM_MODE_PRESCALE;
            end else if (strap_s2 == `CSM_STRAP_DIRECT) begin
                next_mode = csm_pkg::CSM_MODE_DIRECT;
            end else begin
                next_mode = csm_pkg::CSM_MODE_PLL;
            end
        end
        if (oscillator_fail_irq_clear_in) begin
            next_irq = 1'b0;
        end
        if (overflow && mon_on) begin
            next_failed = 1'b1;
            next_irq    = 1'b1;
        end
    end

    // Mode and factor are taken every cycle of reset, so the straps seen
    // at the last reset cycle win; failure clears under reset.
    always_ff @(posedge clock_in) begin
        mode <= next_mode;
        f2   <= next_f2;
        if (srst_in) begin
            failed <= 1'b0;
        end else begin
            failed <= next_failed;
        end
    end

    // Free-running PLL modelled as an enable from a divider.
    logic [7:0] div_cnt;
    logic [7:0] next_div_cnt;
    logic       pll_tick;
    logic       pll_run;

    assign pll_run  = mon_on || failed;
    assign pll_tick = pll_run && div_cnt == 8'(PLL_FREE_DIV - 1);

    always_comb begin
        next_div_cnt = div_cnt + 8'h01;
        if (!pll_run || pll_tick) begin
            next_div_cnt = 8'h00;
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            div_cnt <= 8'h00;
        end else begin
            div_cnt <= next_div_cnt;
        end
    end

    csm_loss_counter #(
        .LIMIT        (MON_LIMIT)
    ) u_loss (
        .clock_in     (clock_in),
        .srst_in      (srst_in),
        .enable_in    (mon_on),
        .clear_in     (osc_edge),
        .inc_in       (pll_tick),
        .overflow_out (overflow)
    );

    // Multiplying PLL: half-period estimate and phase accumulator.
    logic [15:0] est;
    logic [15:0] next_est;
    logic [15:0] hp_cnt;
    logic [15:0] next_hp_cnt;
    logic [3:0]  tr_cnt;
    logic [3:0]  next_tr_cnt;
    logic [17:0] acc;
    logic [17:0] next_acc;
    logic        syn_tick;
    logic [16:0] diff;
    logic [3:0]  f_int;

    // Fractional factors resync on the next whole transition count.
    assign f_int = 4'((5'(f2) + 5'h01) >> 1);
    // At an edge the counter holds one less than the half period.
    assign diff  = {1'b0, hp_cnt} + 17'h00001 - {1'b0, est};

    always_comb begin
        next_hp_cnt = hp_cnt + 16'h0001;
        next_tr_cnt = tr_cnt;
        next_est    = est;
        next_acc    = acc + 18'(f2);
        syn_tick    = 1'b0;
        if (hp_cnt == 16'hffff) begin
            next_hp_cnt = hp_cnt;
        end
        if (osc_edge) begin
            next_hp_cnt = 16'h0000;
            next_tr_cnt = tr_cnt + 4'h1;
            if (tr_cnt + 4'h1 >= f_int) begin
                next_tr_cnt = 4'h0;
                next_est    = est + 16'($signed(diff) >>> 2);
            end
        end
        if (next_acc >= {1'b0, est, 1'b0}) begin
            next_acc = next_acc - {1'b0, est, 1'b0};
            syn_tick = 1'b1;
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in || mode != csm_pkg::CSM_MODE_PLL) begin
            hp_cnt <= 16'h0000;
            tr_cnt <= 4'h0;
            est    <= `CSM_EST_RESET;
            acc    <= 18'h00000;
        end else begin
            hp_cnt <= next_hp_cnt;
            tr_cnt <= next_tr_cnt;
            est    <= next_est;
            acc    <= next_acc;
        end
    end

    // Output stage.
    csm_pkg::csm_status_t st;
    csm_pkg::csm_status_t next_st;

    always_comb begin
        next_st.fail_irq = next_irq;
        next_st.src_pll  = failed || mode == csm_pkg::CSM_MODE_PLL;
        next_st.pll_enable = pll_run || mode == csm_pkg::CSM_MODE_PLL;
        case (mode)
            csm_pkg::CSM_MODE_DIRECT:   next_st.cpu_tick = osc_edge;
            csm_pkg::CSM_MODE_PRESCALE: next_st.cpu_tick = osc_rise;
            csm_pkg::CSM_MODE_PLL:      next_st.cpu_tick = syn_tick;
            default:                    next_st.cpu_tick = 1'b0;
        endcase
        if (failed) begin
            next_st.cpu_tick = pll_tick;
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign cpu_tick_out    = st.cpu_tick;
    assign cpu_src_pll_out = st.src_pll;
    assign pll_enable_out  = st.pll_enable;
    assign oscillator_fail_irq_out = st.fail_irq;
    assign clock_mode_out  = mode;

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (srst_in);

    sequence s_loss;
        overflow && mon_on;
    endsequence

    property p_switch;
        s_loss |=> failed ##1 cpu_src_pll_out;
    endproperty
    a_switch: assert property (p_switch)
        else $error("no switch to PLL after clock loss");

    property p_irq_set;
        s_loss |=> oscillator_fail_irq_out;
    endproperty
    a_irq_set: assert property (p_irq_set)
        else $error("irq flag not set on clock loss");

    property p_stay;
        failed |=> failed;
    endproperty
    a_stay: assert property (p_stay)
        else $error("failsafe left without reset");

    property p_irq_hold;
        oscillator_fail_irq_out && !oscillator_fail_irq_clear_in
            |=> oscillator_fail_irq_out;
    endproperty
    a_irq_hold: assert property (p_irq_hold)
        else $error("irq flag dropped without clear");

    property p_pll_off;
        mon_dis && !failed && mode != csm_pkg::CSM_MODE_PLL
            |=> !pll_enable_out;
    endproperty
    a_pll_off: assert property (p_pll_off)
        else $error("PLL powered while monitor disabled");

    property p_mode_hold;
        !srst_in |=> $stable(mode);
    endproperty
    a_mode_hold: assert property (p_mode_hold)
        else $error("clock mode changed outside reset");

    property p_presc_tick;
        mode == csm_pkg::CSM_MODE_PRESCALE && !failed && osc_rise
            |=> cpu_tick_out;
    endproperty
    a_presc_tick: assert property (p_presc_tick)
        else $error("prescaler tick missing");

    property p_no_mon_pll;
        mode == csm_pkg::CSM_MODE_PLL |-> !mon_on && !failed;
    endproperty
    a_no_mon_pll: assert property (p_no_mon_pll)
        else $error("monitor active in PLL mode");

endmodule // csm_top

// *** tb/csm_osc_model.sv ***
`timescale 1ns/1ps

module csm_osc_model #(
    parameter int HALF = 4
) (
    // Clock.
    input  wire logic clock_in,
    // Control from the bench.
    input  wire logic run_in,
    // Oscillator pin level.
    output logic      osc_out
);
    int cnt;

    initial begin
        osc_out = 1'b0;
        cnt = 0;
    end

    // A stopped source freezes its level, as a dead crystal would.
    always @(posedge clock_in) begin
        if (run_in) begin
            cnt <= (cnt + 1 >= HALF) ? 0 : cnt + 1;
            if (cnt + 1 >= HALF) begin
                osc_out <= #1 ~osc_out;
            end
        end
    end
endmodule // csm_osc_model

// *** tb/csm_top_tb.sv ***
`timescale 1ns/1ps
`include "csm_params.svh"

module csm_top_tb;
    logic                      clock_in = 1'b0;
    logic                      srst_in = 1'b1;
    logic                      osc_run = 1'b0;
    logic                      osc_pin;
    logic [2:0]                straps = 3'h3;
    logic [`CSM_CFG_WIDTH-1:0] cfg = 16'h0000;
    logic                      irq_clr = 1'b0;
    logic                      cpu_tick_out;
    logic                      cpu_src_pll_out;
    logic                      pll_enable_out;
    logic                      oscillator_fail_irq_out;
    logic [1:0]                clock_mode_out;
    int                        err_total = 0;
    int                        n_compared = 0;
    int                        tick_cnt = 0;
    logic [2:0]                pll_codes [6] = '{3'h0, 3'h2, 3'h4,
                                                 3'h5, 3'h6, 3'h7};
    // Factor times ten: the 80-cycle window holds ten input half periods.
    int                        pll_ticks [6] = '{25, 15, 50, 20, 30, 40};

    always #10 clock_in = ~clock_in;

    always @(posedge clock_in) begin
        if (cpu_tick_out === 1'b1) begin
            tick_cnt <= tick_cnt + 1;
        end
    end

    csm_osc_model #(.HALF(8)) csm_osc_model_i (
        .clock_in (clock_in),
        .run_in   (osc_run),
        .osc_out  (osc_pin)
    );

    csm_top #(.PLL_FREE_DIV(2), .MON_LIMIT(16)) csm_top_i (
        .clock_in                     (clock_in),
        .srst_in                      (srst_in),
        .oscillator_input_pin_in      (osc_pin),
        .clock_mode_straps_in         (straps),
        .system_config_register_in    (cfg),
        .oscillator_fail_irq_clear_in (irq_clr),
        .cpu_tick_out                 (cpu_tick_out),
        .cpu_src_pll_out              (cpu_src_pll_out),
        .pll_enable_out               (pll_enable_out),
        .oscillator_fail_irq_out      (oscillator_fail_irq_out),
        .clock_mode_out               (clock_mode_out)
    );

    task automatic cyc(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask

    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Straps must settle through the synchronisers before release.
    task automatic do_reset(input logic [2:0] s, input logic [15:0] c);
        @(posedge clock_in);
        #1;
        srst_in = 1'b1;
        straps = s;
        cfg = c;
        cyc(5);
        srst_in = 1'b0;
        cyc(2);
    endtask

    task automatic tick_rate(input int n, input int lo, input int hi);
        tick_cnt = 0;
        cyc(n);
        chk("tick count in range", 16'h1,
            16'((tick_cnt >= lo) && (tick_cnt <= hi)));
    endtask

    // Stops the source and expects failover in the bounded window.
    task automatic lose_clock();
        int i;
        osc_run = 1'b0;
        cyc(24);
        chk("irq before limit", 16'h0, 16'(oscillator_fail_irq_out));
        for (i = 0; i < 30 && oscillator_fail_irq_out !== 1'b1; i++) begin
            cyc(1);
        end
        chk("irq after loss", 16'h1, 16'(oscillator_fail_irq_out));
        cyc(2);
        chk("src pll after loss", 16'h1, 16'(cpu_src_pll_out));
    endtask

    task automatic t_direct();
        do_reset(3'h3, 16'h0000);
        osc_run = 1'b1;
        chk("mode direct", {14'h0, csm_pkg::CSM_MODE_DIRECT},
            16'(clock_mode_out));
        tick_rate(160, 19, 21);
        chk("pll runs for monitor", 16'h1, 16'(pll_enable_out));
        chk("no irq while clocked", 16'h0, 16'(oscillator_fail_irq_out));
        chk("src osc", 16'h0, 16'(cpu_src_pll_out));
        lose_clock();
        osc_run = 1'b1;
        cyc(60);
        chk("stays on pll", 16'h1, 16'(cpu_src_pll_out));
        chk("irq sticky", 16'h1, 16'(oscillator_fail_irq_out));
        tick_rate(40, 19, 21);
        irq_clr = 1'b1;
        cyc(1);
        irq_clr = 1'b0;
        chk("irq cleared", 16'h0, 16'(oscillator_fail_irq_out));
        $display("test direct done");
    endtask

    task automatic t_prescale();
        do_reset(3'h1, 16'h0000);
        osc_run = 1'b1;
        chk("src back to osc", 16'h0, 16'(cpu_src_pll_out));
        chk("mode prescale", {14'h0, csm_pkg::CSM_MODE_PRESCALE},
            16'(clock_mode_out));
        straps = 3'h7;
        tick_rate(160, 9, 11);
        chk("mode held", {14'h0, csm_pkg::CSM_MODE_PRESCALE},
            16'(clock_mode_out));
        lose_clock();
        $display("test prescale done");
    endtask

    task automatic t_disable();
        do_reset(3'h3, 16'h0010);
        osc_run = 1'b1;
        cyc(2);
        chk("pll off", 16'h0, 16'(pll_enable_out));
        tick_rate(160, 19, 21);
        osc_run = 1'b0;
        cyc(120);
        chk("no irq disabled", 16'h0, 16'(oscillator_fail_irq_out));
        chk("src osc disabled", 16'h0, 16'(cpu_src_pll_out));
        $display("test disable done");
    endtask

    task automatic t_pll();
        int k;
        for (k = 0; k < 6; k++) begin
            do_reset(pll_codes[k], 16'h0000);
            osc_run = 1'b1;
            cyc(40);
            chk("mode pll", {14'h0, csm_pkg::CSM_MODE_PLL},
                16'(clock_mode_out));
            chk("pll on", 16'h1, 16'(pll_enable_out));
            chk("src pll", 16'h1, 16'(cpu_src_pll_out));
            cyc(260);
            tick_rate(80, pll_ticks[k] - 1, pll_ticks[k] + 1);
            osc_run = 1'b0;
            cyc(120);
            chk("pll mode unmonitored", 16'h0,
                16'(oscillator_fail_irq_out));
        end
        $display("test pll done");
    endtask

    task automatic wrap_up();
        $display("compared %0d mismatched %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        t_direct();
        t_prescale();
        t_disable();
        t_pll();
        wrap_up();
    end

    // The run needs about 4000 cycles; this leaves a margin of two.
    initial begin
        #(20 * 8000);
        err_total++;
        wrap_up();
    end
endmodule // csm_top_tb
